//--- src/flash_status_defs.svh
// Purpose: constants of the status register and write-permission block
// Assumes: 100 MHz system clock
// Notes: definitions only
`ifndef FLASH_STATUS_DEFS_SVH
`define FLASH_STATUS_DEFS_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define CMD_STATUS_STORE 8'h01
`define CMD_PAGE_WRITE 8'h02
`define CMD_WRITE_FORBID 8'h04
`define CMD_STATUS_FETCH 8'h05
`define CMD_WRITE_PERMIT 8'h06
`define CMD_SECTOR_WIPE 8'h20
`define CMD_QUAD_PAGE_WRITE 8'h32
`define CMD_QUAD_BUS_ENTRY 8'h38
`define CMD_VOLATILE_PERMIT 8'h50
`define CMD_HALF_BLOCK_WIPE 8'h52
`define CMD_CHIP_WIPE_A 8'h60
`define CMD_RESET_ARM 8'h66
`define CMD_RESET_GO 8'h99
`define CMD_CHIP_WIPE_B 8'hc7
`define CMD_BLOCK_WIPE 8'hd8
`define CMD_QUAD_BUS_EXIT 8'hff

// ----------------------------------------------------------------
// status byte layout
// ----------------------------------------------------------------
`define SR_BUSY_POS 0
`define SR_PERMIT_POS 1
`define SR_SIZE_LO_POS 2
`define SR_SIZE_HI_POS 4
`define SR_ORIGIN_POS 5
`define SR_SMALL_POS 6
`define SR_LOCK_POS 7
`define SR_STORED_RESET 6'h00

// ----------------------------------------------------------------
// frame field lengths in bits
// ----------------------------------------------------------------
`define OPCODE_BITS 6'h08
`define STATUS_DATA_BITS 6'h08
`define ADDR_BITS 6'h18
`define ADDR_DATA_BITS 6'h20

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define STORE_TIME_NS 1000
`define STORE_CYCLES ((`STORE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define VOLATILE_LOAD_NS 50
`define VOLATILE_LOAD_CYCLES (`VOLATILE_LOAD_NS / `CLK_PERIOD_NS)

`endif

//--- src/flash_status_pkg.sv
// Purpose: types of the status register and write-permission block
// Assumes: constants live in flash_status_defs.svh
// Notes: one-hot frame states
package flash_status_pkg;

    // ----------------------------------------------------------------
    // serial frame phases
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FR_OPCODE = 3'b001,
        FR_COLLECT = 3'b010,
        FR_SEND = 3'b100
    } frame_state_t;

endpackage

//--- src/flash_status_write_protect.sv
// Purpose: status byte, write-permit latch and protection of a serial flash
// Assumes: all pins synchronous to mclk_i, serial clock well below mclk_i
// Notes: array program/erase itself runs outside, started by op_start_o
//
// Overview of operation
// - 50h arms volatile status write, latch untouched
// - armed 01h loads volatile bits 7..2 quickly
// - reset pin or 66h then 99h restores volatile bits from stored
// - 04h frame clears the write-permit latch
// - latch clears at power-up and cycle end
// - 05h status read accepted even while busy
// - status byte repeats while select stays low
// - bit 0 shows busy cycle, read-only
// - bit 1 shows latch; latch low rejects stored and array writes, not armed volatile loads
// - nonzero size bits lock selected area
// - size bits writable only outside hardware lock
// - chip erase only with no protection bits
// - bit 5 chooses top or bottom origin
// - bit 6 chooses sector or block units
// - lock bit plus low protect pin rejects stores
// - 50h, 04h, 05h also work on quad bus
// - 06h sets the write-permit latch
// - 38h makes later frames 4-bit until FFh or reset
`timescale 1ns/1ps
`include "flash_status_defs.svh"

module flash_status_write_protect #(
    parameter int STORE_CYCLES = `STORE_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic [3:0] dq_i,
    input wire logic wp_n_i,
    input wire logic hw_reset_n_i,
    input wire logic protect_invert_bit_i,
    input wire logic area_locked_i,
    input wire logic op_done_i,
    output logic [3:0] dq_o,
    output logic [3:0] dq_oe_n_o,
    output logic [7:0] status_byte_o,
    output logic hw_protect_o,
    output logic quad_mode_o,
    output logic op_start_o,
    output logic op_abort_o,
    output logic [7:0] op_code_o,
    output logic [23:0] op_addr_o
);
    import flash_status_pkg::*;

    localparam int CNT_W = $clog2(STORE_CYCLES + 1);

    if (STORE_CYCLES < 1) begin : g_bad_store
        $error("STORE_CYCLES must be at least 1");
    end

    // ----------------------------------------------------------------
    // opcode classes
    // ----------------------------------------------------------------
    function automatic logic is_program(input logic [7:0] op);
        return (op == `CMD_PAGE_WRITE) || (op == `CMD_QUAD_PAGE_WRITE);
    endfunction

    function automatic logic is_erase(input logic [7:0] op);
        return (op == `CMD_SECTOR_WIPE) || (op == `CMD_HALF_BLOCK_WIPE)
            || (op == `CMD_BLOCK_WIPE);
    endfunction

    function automatic logic is_chip_erase(input logic [7:0] op);
        return (op == `CMD_CHIP_WIPE_A) || (op == `CMD_CHIP_WIPE_B);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    frame_state_t state;
    logic sclk_q;
    logic cs_n_q;
    logic [5:0] cnt;
    logic [31:0] shreg;
    logic [7:0] opcode;
    logic op_valid;
    logic [7:0] tx_sh;
    logic [2:0] tx_left;
    logic [5:0] volatile_bits;
    logic [5:0] stored_bits;
    logic [5:0] store_val;
    logic write_permit_latch;
    logic volatile_arm;
    logic reset_arm;
    logic quad;
    logic store_busy;
    logic [CNT_W-1:0] store_cnt;
    logic array_busy;
    logic pend;
    logic pend_chip;

    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;
    logic cmd_done;
    logic busy_cycle_flag;
    logic status_lock_bit;
    logic hw_lock;
    logic [5:0] step;
    logic [31:0] next_shreg;
    logic [7:0] status_now;
    logic [7:0] next_byte;
    logic soft_reset;
    logic store_finish;
    logic array_go;
    logic chip_clear;

    // ----------------------------------------------------------------
    // pin edges and derived flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= sclk_i;
            cs_n_q <= cs_n_i;
        end
    end

    assign sclk_rise = sclk_i & ~sclk_q & ~cs_n_i;
    assign sclk_fall = ~sclk_i & sclk_q & ~cs_n_i;
    assign frame_end = cs_n_i & ~cs_n_q;
    assign cmd_done = frame_end & op_valid;
    assign step = quad ? 6'h04 : 6'h01;
    assign next_shreg = quad ? {shreg[27:0], dq_i} : {shreg[30:0], dq_i[0]};
    assign busy_cycle_flag = store_busy | array_busy;
    assign status_lock_bit = volatile_bits[`SR_LOCK_POS - 2];
    assign hw_lock = status_lock_bit & ~wp_n_i;
    assign status_now = {volatile_bits, write_permit_latch, busy_cycle_flag};
    assign chip_clear = ~protect_invert_bit_i && (volatile_bits[4:0] == 5'h00);
    assign store_finish = store_busy && (store_cnt == '0);
    assign array_go = pend && (pend_chip || ~area_locked_i);

    // ----------------------------------------------------------------
    // command decode at frame end
    // ----------------------------------------------------------------
    logic do_permit;
    logic do_forbid;
    logic do_vol_load;
    logic do_store;
    logic do_array;

    always_comb begin
        do_permit = 1'b0;
        do_forbid = 1'b0;
        do_vol_load = 1'b0;
        do_store = 1'b0;
        do_array = 1'b0;
        if (cmd_done && !busy_cycle_flag && !pend) begin
            unique case (opcode)
                `CMD_WRITE_PERMIT: do_permit = (cnt == 6'h00);
                `CMD_WRITE_FORBID: do_forbid = (cnt == 6'h00);
                `CMD_STATUS_STORE: begin
                    if (cnt == `STATUS_DATA_BITS && !hw_lock) begin
                        do_vol_load = volatile_arm;
                        do_store = ~volatile_arm & write_permit_latch;
                    end
                end
                default: begin
                    if (write_permit_latch) begin
                        if (is_program(opcode)) begin
                            do_array = (cnt == `ADDR_DATA_BITS);
                        end else if (is_erase(opcode)) begin
                            do_array = (cnt == `ADDR_BITS);
                        end else if (is_chip_erase(opcode)) begin
                            do_array = (cnt == 6'h00) && chip_clear;
                        end
                    end
                end
            endcase
        end
    end

    assign soft_reset = ~hw_reset_n_i
        | (cmd_done && opcode == `CMD_RESET_GO && reset_arm && cnt == 6'h00);

    // ----------------------------------------------------------------
    // frame receiver
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i || cs_n_i) begin
            state <= FR_OPCODE;
            opcode <= 8'h00;
            cnt <= 6'h00;
            shreg <= 32'h0000_0000;
            op_valid <= 1'b0;
        end else if (sclk_rise) begin
            unique case (state)
                FR_OPCODE: begin
                    if (cnt + step == `OPCODE_BITS) begin
                        opcode <= next_shreg[7:0];
                        op_valid <= 1'b1;
                        cnt <= 6'h00;
                        shreg <= 32'h0000_0000;
                        if (next_shreg[7:0] == `CMD_STATUS_FETCH) begin
                            state <= FR_SEND;
                        end else begin
                            state <= FR_COLLECT;
                        end
                    end else begin
                        shreg <= next_shreg;
                        cnt <= cnt + step;
                    end
                end
                FR_COLLECT: begin
                    if (cnt < `ADDR_DATA_BITS) begin
                        shreg <= next_shreg;
                        cnt <= cnt + step;
                    end
                end
                FR_SEND: begin
                    cnt <= cnt;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // status transmitter
    // ----------------------------------------------------------------
    assign next_byte = (tx_left == 3'h0) ? status_now : tx_sh;

    always_ff @(posedge mclk_i) begin
        if (rst_i || cs_n_i) begin
            dq_o <= 4'h0;
            dq_oe_n_o <= 4'hf;
            tx_sh <= 8'h00;
            tx_left <= 3'h0;
        end else if (sclk_fall && state == FR_SEND) begin
            if (quad) begin
                dq_o <= next_byte[7:4];
                dq_oe_n_o <= 4'h0;
                tx_sh <= {next_byte[3:0], 4'h0};
                tx_left <= (tx_left == 3'h0) ? 3'h1 : tx_left - 3'h1;
            end else begin
                dq_o <= {2'b00, next_byte[7], 1'b0};
                dq_oe_n_o <= 4'hd;
                tx_sh <= {next_byte[6:0], 1'b0};
                tx_left <= (tx_left == 3'h0) ? 3'h7 : tx_left - 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // protection bits, latch and modes
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            volatile_bits <= `SR_STORED_RESET;
            stored_bits <= `SR_STORED_RESET;
            write_permit_latch <= 1'b0;
            volatile_arm <= 1'b0;
            reset_arm <= 1'b0;
            quad <= 1'b0;
        end else if (soft_reset) begin
            volatile_bits <= stored_bits;
            write_permit_latch <= 1'b0;
            volatile_arm <= 1'b0;
            reset_arm <= 1'b0;
            quad <= 1'b0;
        end else begin
            if (cmd_done && opcode != `CMD_STATUS_FETCH) begin
                volatile_arm <= (opcode == `CMD_VOLATILE_PERMIT) && !busy_cycle_flag;
                reset_arm <= (opcode == `CMD_RESET_ARM);
            end
            if (do_vol_load) begin
                volatile_bits <= shreg[7:2];
            end else if (store_finish) begin
                volatile_bits <= store_val;
                stored_bits <= store_val;
            end
            if (do_permit) begin
                write_permit_latch <= 1'b1;
            end else if (do_forbid || store_finish || (array_busy && op_done_i)) begin
                write_permit_latch <= 1'b0;
            end
            if (cmd_done && !busy_cycle_flag && cnt == 6'h00) begin
                if (!quad && opcode == `CMD_QUAD_BUS_ENTRY) begin
                    quad <= 1'b1;
                end else if (quad && opcode == `CMD_QUAD_BUS_EXIT) begin
                    quad <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // stored status write cycle
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i || soft_reset) begin
            store_busy <= 1'b0;
            store_cnt <= '0;
            store_val <= 6'h00;
        end else if (do_store) begin
            store_busy <= 1'b1;
            store_cnt <= CNT_W'(STORE_CYCLES - 1);
            store_val <= shreg[7:2];
        end else if (store_finish) begin
            store_busy <= 1'b0;
        end else if (store_busy) begin
            store_cnt <= store_cnt - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // array program and erase hand-off
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pend <= 1'b0;
            pend_chip <= 1'b0;
            array_busy <= 1'b0;
            op_start_o <= 1'b0;
            op_abort_o <= 1'b0;
            op_code_o <= 8'h00;
            op_addr_o <= 24'h00_0000;
        end else if (soft_reset) begin
            pend <= 1'b0;
            array_busy <= 1'b0;
            op_start_o <= 1'b0;
            op_abort_o <= array_busy;
        end else begin
            op_start_o <= 1'b0;
            op_abort_o <= 1'b0;
            if (do_array) begin
                pend <= 1'b1;
                pend_chip <= is_chip_erase(opcode);
                op_code_o <= opcode;
                op_addr_o <= is_program(opcode) ? shreg[31:8] : shreg[23:0];
            end else if (pend) begin
                pend <= 1'b0;
                op_start_o <= array_go;
                array_busy <= array_go;
            end else if (array_busy && op_done_i) begin
                array_busy <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // registered status view
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_byte_o <= 8'h00;
            hw_protect_o <= 1'b0;
            quad_mode_o <= 1'b0;
        end else begin
            status_byte_o <= status_now;
            hw_protect_o <= hw_lock;
            quad_mode_o <= quad;
        end
    end

endmodule

//--- dv/spi_host_model.sv
// Purpose: serial flash host controller model
// Assumes: mode 0, four system clocks per serial clock when sending, six when reading status
// Notes: after a frame the data lines show the inverse of their last value
`timescale 1ns/1ps

module spi_host_model (
    input wire logic mclk_i,
    input wire logic [3:0] miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic [3:0] mosi_o
);
    logic quad_bus = 1'h0;

    initial begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        mosi_o = 4'h0;
    end

    // ----------------------------------------
    // framing and shifting
    // ----------------------------------------
    task automatic shift_out(input logic [31:0] v, input int n);
        int i;
        i = n;
        while (i > 0) begin
            i = quad_bus ? i - 4 : i - 1;
            mosi_o <= quad_bus ? v[i +: 4] : {3'h0, v[i]};
            repeat (2) @(posedge mclk_i);
            sclk_o <= 1'h1;
            repeat (2) @(posedge mclk_i);
            sclk_o <= 1'h0;
        end
    endtask

    task automatic open_frame(input logic [7:0] op);
        cs_n_o <= 1'h0;
        @(posedge mclk_i);
        shift_out({24'h0, op}, 8);
    endtask

    task automatic close_frame();
        @(posedge mclk_i);
        cs_n_o <= 1'h1;
        mosi_o <= ~mosi_o;
        repeat (4) @(posedge mclk_i);
    endtask

    task automatic frame(input logic [7:0] op, input logic [31:0] arg, input int n);
        open_frame(op);
        shift_out(arg, n);
        close_frame();
    endtask

    // polls two status bytes under one opcode
    task automatic read_status(output logic [15:0] v);
        open_frame(8'h05);
        v = 16'h0;
        for (int k = 0; k < (quad_bus ? 4 : 16); k++) begin
            repeat (4) @(posedge mclk_i);
            v = quad_bus ? {v[11:0], miso_i} : {v[14:0], miso_i[1]};
            sclk_o <= 1'h1;
            repeat (2) @(posedge mclk_i);
            sclk_o <= 1'h0;
        end
        close_frame();
    endtask
endmodule

//--- dv/flash_status_write_protect_props.sv
// Purpose: port checks of the status and write-protect block
// Assumes: bound to every instance of the block
// Notes: status view lags internal state by one clock
`timescale 1ns/1ps

module flash_status_write_protect_props #(
    parameter int STORE_CYCLES = 100
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic protect_invert_bit_i,
    input wire logic op_done_i,
    input wire logic [3:0] dq_oe_n_o,
    input wire logic [7:0] status_byte_o,
    input wire logic hw_protect_o,
    input wire logic quad_mode_o,
    input wire logic op_start_o,
    input wire logic [7:0] op_code_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_start_needs_latch: assert property (op_start_o |-> status_byte_o[1])
        else $error("array op started without write permit");
    a_start_sets_busy: assert property (op_start_o |-> ##[1:2] status_byte_o[0])
        else $error("busy not shown after array op start");
    a_latch_not_busy: assert property ($rose(status_byte_o[1])
        |-> !$past(status_byte_o[0]))
        else $error("write permit set while busy");
    a_done_clears_both: assert property (op_done_i && status_byte_o[0]
        |-> ##2 status_byte_o[1:0] == 2'h0)
        else $error("busy or permit left after op end");
    a_hw_lock_view: assert property (hw_protect_o
        == (status_byte_o[7] && !$past(wp_n_i)))
        else $error("hardware protect flag wrong");
    a_locked_store_held: assert property (hw_protect_o && $rose(cs_n_i)
        |=> $stable(status_byte_o[7:2]) [*4])
        else $error("protection bits changed under hardware lock");
    a_chip_wipe_clean: assert property (op_start_o && op_code_o inside {8'hc7, 8'h60}
        |-> status_byte_o[6:2] == 5'h00 && !protect_invert_bit_i)
        else $error("chip erase started with protection set");
    a_quad_enables: assert property (quad_mode_o && dq_oe_n_o != 4'hf
        |-> dq_oe_n_o == 4'h0)
        else $error("quad send not on all four lines");
    a_single_enables: assert property (!quad_mode_o && dq_oe_n_o != 4'hf
        |-> dq_oe_n_o == 4'hd)
        else $error("single send not on line one");
    a_idle_released: assert property (cs_n_i [*3] |-> dq_oe_n_o == 4'hf)
        else $error("output driven while deselected");

    c_array_start: cover property (op_start_o);
    c_locked_frame: cover property (hw_protect_o && $rose(cs_n_i));
    c_quad_send: cover property (quad_mode_o && dq_oe_n_o == 4'h0);
endmodule

bind flash_status_write_protect flash_status_write_protect_props #(
    .STORE_CYCLES(STORE_CYCLES)
) u_props (
    .mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .wp_n_i(wp_n_i),
    .protect_invert_bit_i(protect_invert_bit_i), .op_done_i(op_done_i),
    .dq_oe_n_o(dq_oe_n_o), .status_byte_o(status_byte_o), .hw_protect_o(hw_protect_o),
    .quad_mode_o(quad_mode_o), .op_start_o(op_start_o), .op_code_o(op_code_o)
);

//--- dv/flash_status_write_protect_tb_top.sv
// Purpose: self-checking bench of the status and write-protect block
// Assumes: host model drives the link, bench drives the side pins
// Notes: stored write time lengthened to 200 clocks
`timescale 1ns/1ps

module flash_status_write_protect_tb_top;
    import flash_status_pkg::*;

    logic mclk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wp_n = 1'h1;
    logic hw_reset_n = 1'h1;
    logic invert_bit = 1'h0;
    logic area_locked = 1'h0;
    logic op_done = 1'h0;
    logic sclk, cs_n, hw_protect, quad_mode, op_start, op_abort;
    logic [3:0] mosi, dq, dq_out, dq_oe_n;
    logic [7:0] status_byte, op_code, last_code;
    logic [23:0] op_addr;
    logic [15:0] rd;
    int err_total = 0;
    int n_checks = 0;
    int starts = 0;
    int aborts = 0;
    int cycles = 0;

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    assign dq = (dq_out & ~dq_oe_n) | (mosi & dq_oe_n);

    spi_host_model HOST (.mclk_i(mclk_i), .miso_i(dq), .sclk_o(sclk), .cs_n_o(cs_n),
        .mosi_o(mosi));

    flash_status_write_protect #(.STORE_CYCLES(200)) DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .dq_i(dq),
        .wp_n_i(wp_n), .hw_reset_n_i(hw_reset_n), .protect_invert_bit_i(invert_bit),
        .area_locked_i(area_locked), .op_done_i(op_done), .dq_o(dq_out),
        .dq_oe_n_o(dq_oe_n), .status_byte_o(status_byte), .hw_protect_o(hw_protect),
        .quad_mode_o(quad_mode), .op_start_o(op_start), .op_abort_o(op_abort),
        .op_code_o(op_code), .op_addr_o(op_addr)
    );

    // ----------------------------------------
    // pulse counters, timeout and helpers
    // ----------------------------------------
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (op_start === 1'h1) begin
            starts <= starts + 1;
            last_code <= op_code;
        end
        if (op_abort === 1'h1) begin
            aborts <= aborts + 1;
        end
        if (cycles == 20000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        HOST.frame(op, 32'h0, 0);
    endtask

    // bench polls busy on status_byte before the next instruction
    task automatic wait_ready();
        int i;
        i = 0;
        while (status_byte[0] !== 1'h0 && i < 600) begin
            cyc(1);
            i++;
        end
    endtask

    task automatic pulse_done();
        op_done <= 1'h1;
        cyc(1);
        op_done <= 1'h0;
        cyc(3);
    endtask

    task automatic endt(input string name);
        $display("test %s done", name);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        cyc(5);
        rst_i <= 1'h0;
        cyc(1);
        check("reset_status", {dq_oe_n, status_byte}, 12'hf00);
        cmd(8'h50);
        check("arm_latch", status_byte, 8'h00);
        cmd(8'h06);
        check("latch_set", status_byte, 8'h02);
        cmd(8'h04);
        check("latch_clear", status_byte, 8'h00);
        HOST.frame(8'h20, 32'h001000, 24);
        check("erase_no_latch", starts, 32'h0);
        cmd(8'h06);
        HOST.frame(8'h01, 32'h7c, 8);
        check("store_busy", status_byte, 8'h03);
        HOST.read_status(rd);
        check("read_busy", rd, 16'h0303);
        wait_ready();
        check("store_done", status_byte, 8'h7c);
        endt("latch_store");
        area_locked <= 1'h1;
        cmd(8'h06);
        HOST.frame(8'hd8, 32'h3f0000, 24);
        check("locked_area", {starts[7:0], status_byte}, 16'h007e);
        area_locked <= 1'h0;
        cmd(8'hc7);
        check("chip_refused", starts, 32'h0);
        HOST.frame(8'h52, 32'h018000, 24);
        check("erase_start", {last_code, op_addr}, 32'h52018000);
        HOST.read_status(rd);
        check("read_erase", rd, 16'h7f7f);
        pulse_done();
        check("erase_done", status_byte, 8'h7c);
        endt("protect");
        cmd(8'h50);
        HOST.frame(8'h01, 32'h00, 8);
        check("volatile_load", status_byte, 8'h00);
        cmd(8'h66);
        cmd(8'h99);
        check("soft_reset", status_byte, 8'h7c);
        cmd(8'h06);
        HOST.frame(8'h01, 32'hfc, 8);
        wait_ready();
        check("stored_lock", status_byte, 8'hfc);
        wp_n <= 1'h0;
        cmd(8'h06);
        HOST.frame(8'h01, 32'h00, 8);
        check("hw_lock", {hw_protect, status_byte[7:2]}, 7'h7f);
        cmd(8'h50);
        HOST.frame(8'h01, 32'h00, 8);
        check("hw_lock_vol", status_byte[7:2], 6'h3f);
        wp_n <= 1'h1;
        cmd(8'h06);
        HOST.frame(8'h01, 32'h00, 8);
        wait_ready();
        check("unlocked", status_byte, 8'h00);
        invert_bit <= 1'h1;
        cmd(8'h06);
        cmd(8'h60);
        check("chip_invert", starts, 32'h1);
        invert_bit <= 1'h0;
        cmd(8'h60);
        check("chip_wipe", {starts[7:0], last_code}, 16'h0260);
        pulse_done();
        endt("hw_lock");
        cmd(8'h38);
        HOST.quad_bus = 1'h1;
        check("quad_on", quad_mode, 1'h1);
        cmd(8'h06);
        HOST.read_status(rd);
        check("quad_read", rd, 16'h0202);
        cmd(8'h50);
        HOST.frame(8'h01, 32'h10, 8);
        check("quad_volatile", status_byte, 8'h12);
        cmd(8'h04);
        check("quad_forbid", status_byte, 8'h10);
        cmd(8'h06);
        HOST.frame(8'h32, 32'h000100a5, 32);
        check("quad_program", {last_code, op_addr}, 32'h32000100);
        pulse_done();
        cmd(8'hff);
        HOST.quad_bus = 1'h0;
        check("quad_exit", quad_mode, 1'h0);
        cmd(8'h38);
        HOST.quad_bus = 1'h1;
        cmd(8'h06);
        HOST.frame(8'h20, 32'h002000, 24);
        hw_reset_n <= 1'h0;
        cyc(2);
        hw_reset_n <= 1'h1;
        HOST.quad_bus = 1'h0;
        cyc(3);
        check("hw_reset", {aborts[3:0], quad_mode, status_byte}, 13'h0200);
        endt("quad");
        finish_test();
    end
endmodule
